// file: tb/can_transceiver_wake_fault_ctrl_tb.sv
// Purpose: Self-checking bench joining host and device ends.
// Assumes: Timeouts shortened to 50 cycles.
// Notes:   Waits are bounded; a spent bound fails the run.
`timescale 1ns/1ns
`include "ctw_defs.svh"
`define CHK(a, e) begin samplesChecked++; if ((a) !== (e)) begin \
	errCount++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); \
	end end
module can_transceiver_wake_fault_ctrl_tb;
	logic        sys_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic        hreadyout;
	logic [31:0] hrdata;
	logic        ctrlTxd = 1'b1;
	logic        ctrlRxd;
	logic        busDominantPin = 1'b0;
	logic        supplyLowPin = 1'b0;
	logic        failSafeReq = 1'b0;
	logic        busDriveDominant;
	logic        hresp;
	logic        supplyOn;
	int          errCount = 0;
	int          samplesChecked = 0;
	ctw_link_if link();
	ctw_host ctw_host_i(.sys_clk, .arst_n, .hsel(1'b1), .haddr, .htrans,
		.hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout,
		.hrdata, .hresp, .link(link.host), .ctrlTxd, .ctrlRxd,
		.supplyOn);
	ctw_device #(.TXD_TO_CYC(50), .BUS_TO_CYC(50)) ctw_device_i(.sys_clk,
		.arst_n, .link(link.device), .busDominantPin, .supplyLowPin,
		.failSafeReq, .busDriveDominant);
	ctw_link_monitor #(.TXD_TO_CYC(50)) ctw_link_monitor_i(.sys_clk,
		.arst_n, .busTransmitIn(link.busTransmitIn),
		.busReceiveOut(link.busReceiveOut), .intN(link.intN),
		.modeWr(link.modeWr), .modeData(link.modeData),
		.clrWr(link.clrWr),
		.watchdogOnBusWakeEnable(link.watchdogOnBusWakeEnable),
		.trxMode(link.trxMode), .chipMode(link.chipMode),
		.busWakeFlag(link.busWakeFlag), .trxFailFlag(link.trxFailFlag),
		.transceiverSupplyLowFlag(link.transceiverSupplyLowFlag),
		.watchdogOn(link.watchdogOn));

	always #20 sys_clk = ~sys_clk;

	task printVerdict;
		if (errCount == 0 && samplesChecked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task waitRdy;
		int i;
		i = 0;
		@(posedge sys_clk);
		while (hreadyout !== 1'b1) begin
			i++;
			if (i > 50) begin
				errCount++;
				printVerdict;
			end
			@(posedge sys_clk);
		end
	endtask
	task acc(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		waitRdy;
		htrans <= 2'h0;
		hwdata <= d;
		waitRdy;
		q = hrdata;
	endtask
	// Mode writes reach the device three edges after the data phase
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		acc(1'b1, a, d, q);
		cyc(3);
	endtask
	task stat(input logic [31:0] e);
		logic [31:0] q;
		acc(1'b0, `CTW_REG_STAT, 32'h0, q);
		`CHK(q & 32'hBFF, e)
		`CHK(hresp, 1'b0)
	endtask
	// Dominant phase well past the wake filter, short of the bus timeout
	task wk;
		busDominantPin <= 1'b1;
		cyc(40);
		busDominantPin <= 1'b0;
		cyc(8);
	endtask
	task waitNormal(output logic seen);
		seen = 1'b0;
		for (int i = 0; i < 200 && link.chipMode != ctw_pkg::CHIP_NORMAL;
			i++) begin
			if (link.chipMode == ctw_pkg::CHIP_RESTART) seen = 1'b1;
			cyc(1);
		end
		`CHK(link.chipMode, ctw_pkg::CHIP_NORMAL)
		// A restart that never ends would stall every later scenario
		if (link.chipMode !== ctw_pkg::CHIP_NORMAL) begin
			printVerdict;
		end
	endtask
	task tOff;
		logic [31:0] q;
		stat(32'h300);
		acc(1'b0, 8'h20, 32'h0, q);
		`CHK(q, 32'h0)
		wk;
		stat(32'h300);
	endtask
	task tStop;
		wr(`CTW_REG_CFG, 32'h1);
		wr(`CTW_REG_MODE, 32'h1);
		`CHK(supplyOn, 1'b0)
		wr(`CTW_REG_CHIP, 32'h1);
		wk;
		stat(32'h825);
		wr(`CTW_REG_MODE, 32'h2);
		// Host copy of receive trails the device by one edge
		cyc(1);
		`CHK(ctrlRxd, 1'b1)
		wr(`CTW_REG_MODE, 32'h1);
		// Wake flag left set: the mode toggle alone must re-arm
		wk;
		`CHK(ctrlRxd, 1'b0)
		`CHK(link.busWakeFlag, 1'b1)
		wr(`CTW_REG_CLR, 32'h1);
		wk;
		`CHK(link.busWakeFlag, 1'b0)
		wr(`CTW_REG_CHIP, 32'h0);
		wr(`CTW_REG_CHIP, 32'h1);
		wk;
		`CHK(link.busWakeFlag, 1'b1)
		`CHK(ctrlRxd, 1'b0)
	endtask
	task tSleep;
		logic seen;
		// The last wake disarmed; off and back re-arms before sleep
		wr(`CTW_REG_MODE, 32'h0);
		wr(`CTW_REG_MODE, 32'h1);
		wr(`CTW_REG_CLR, 32'h1);
		wr(`CTW_REG_CHIP, 32'h2);
		`CHK(link.chipMode, ctw_pkg::CHIP_SLEEP)
		wk;
		waitNormal(seen);
		`CHK(seen, 1'b1)
		stat(32'hA21);
	endtask
	task tFail;
		logic seen;
		wr(`CTW_REG_MODE, 32'h2);
		wr(`CTW_REG_MODE, 32'h1);
		failSafeReq <= 1'b1;
		cyc(2);
		failSafeReq <= 1'b0;
		cyc(2);
		`CHK(link.chipMode, ctw_pkg::CHIP_FAILSAFE)
		wk;
		`CHK(link.chipMode, ctw_pkg::CHIP_RESTART)
		`CHK(link.intN, 1'b1)
		waitNormal(seen);
	endtask
	task tTx;
		logic [31:0] q;
		wr(`CTW_REG_MODE, 32'h3);
		`CHK(supplyOn, 1'b1)
		ctrlTxd <= 1'b0;
		cyc(10);
		`CHK(busDriveDominant, 1'b0)
		ctrlTxd <= 1'b1;
		wr(`CTW_REG_CHIP, 32'h2);
		acc(1'b0, `CTW_REG_STAT, 32'h0, q);
		`CHK(q[10], 1'b1)
		`CHK(link.chipMode, ctw_pkg::CHIP_NORMAL)
		cyc(260);
		ctrlTxd <= 1'b0;
		cyc(6);
		`CHK(busDriveDominant, 1'b1)
		cyc(64);
		`CHK(link.trxFailFlag, 1'b1)
		`CHK(busDriveDominant, 1'b0)
		`CHK(link.trxMode, 2'h3)
		ctrlTxd <= 1'b1;
		cyc(4);
		ctrlTxd <= 1'b0;
		cyc(4);
		`CHK(busDriveDominant, 1'b1)
		ctrlTxd <= 1'b1;
	endtask
	task tBusUv;
		wr(`CTW_REG_CLR, 32'h1);
		busDominantPin <= 1'b1;
		cyc(70);
		`CHK(link.trxFailFlag, 1'b1)
		`CHK(link.trxMode, 2'h3)
		busDominantPin <= 1'b0;
		cyc(6);
		wr(`CTW_REG_CLR, 32'h1);
		supplyLowPin <= 1'b1;
		ctrlTxd <= 1'b0;
		cyc(8);
		`CHK(link.transceiverSupplyLowFlag, 1'b1)
		`CHK(busDriveDominant, 1'b0)
		supplyLowPin <= 1'b0;
		ctrlTxd <= 1'b1;
		cyc(8);
		ctrlTxd <= 1'b0;
		cyc(4);
		`CHK(busDriveDominant, 1'b1)
		`CHK(link.trxMode, 2'h3)
		ctrlTxd <= 1'b1;
	endtask

	initial begin
		cyc(5);
		arst_n <= 1'b1;
		cyc(4);
		tOff;
		tStop;
		tSleep;
		tFail;
		tTx;
		tBusUv;
		cyc(4);
		printVerdict;
	end
endmodule

// file: tb/ctw_link_monitor.sv
// Purpose: Concurrent checks on the link between host and device ends.
// Assumes: One clock domain; reset asynchronous, active low.
// Notes:   TXD_TO_CYC must match the device instance.
`timescale 1ns/1ns
module ctw_link_monitor #(
	parameter int unsigned TXD_TO_CYC = 50
) (
	input wire logic               sys_clk,
	input wire logic               arst_n,
	input wire logic               busTransmitIn,
	input wire logic               busReceiveOut,
	input wire logic               intN,
	input wire logic               modeWr,
	input wire ctw_pkg::ctw_trx_t  modeData,
	input wire logic               clrWr,
	input wire logic               watchdogOnBusWakeEnable,
	input wire ctw_pkg::ctw_trx_t  trxMode,
	input wire ctw_pkg::ctw_chip_t chipMode,
	input wire logic               busWakeFlag,
	input wire logic               trxFailFlag,
	input wire logic               transceiverSupplyLowFlag,
	input wire logic               watchdogOn
);
	logic [15:0] txdLowCnt_reg;
	logic [15:0] txdLowCnt_next;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	// Saturates so a stuck transmit line cannot wrap the count
	always_comb begin
		txdLowCnt_next = 16'h0000;
		if (trxMode == 2'h3 && !busTransmitIn) begin
			txdLowCnt_next = txdLowCnt_reg;
			if (txdLowCnt_reg != 16'hFFFF) begin
				txdLowCnt_next = txdLowCnt_reg + 16'h0001;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			txdLowCnt_reg <= 16'h0000;
		end else begin
			txdLowCnt_reg <= txdLowCnt_next;
		end
	end

	sequence wakeAwake;
		$rose(busWakeFlag) && ($past(chipMode) == ctw_pkg::CHIP_NORMAL
			|| $past(chipMode) == ctw_pkg::CHIP_STOP);
	endsequence

	sequence wakeAsleep;
		$rose(busWakeFlag) && ($past(chipMode) == ctw_pkg::CHIP_SLEEP
			|| $past(chipMode) == ctw_pkg::CHIP_RESTART
			|| $past(chipMode) == ctw_pkg::CHIP_FAILSAFE);
	endsequence

	AST_WAKE_RXD_LOW: assert property ($rose(busWakeFlag) |->
		!busReceiveOut && trxMode == 2'h1)
		else $error("receive not low or mode moved at wake");
	AST_RXD_HELD: assert property (trxMode == 2'h1 && !busReceiveOut
		&& !(modeWr && modeData != 2'h1) |=> !busReceiveOut)
		else $error("receive released without a mode change");
	AST_WAKE_AWAKE_INT: assert property (wakeAwake |->
		!intN && chipMode == $past(chipMode))
		else $error("awake wake lacks interrupt or changed chip mode");
	AST_WAKE_WDOG: assert property (wakeAwake ##0
		($past(chipMode) == ctw_pkg::CHIP_STOP && watchdogOnBusWakeEnable)
		|-> watchdogOn)
		else $error("watchdog not enabled by stop wake");
	AST_WAKE_ASLEEP: assert property (wakeAsleep |->
		$stable(intN) && chipMode == ctw_pkg::CHIP_RESTART)
		else $error("asleep wake gave interrupt or missed restart");
	AST_RESTART_EXIT: assert property (
		$rose(chipMode == ctw_pkg::CHIP_RESTART)
		|-> ##[1:120] chipMode == ctw_pkg::CHIP_NORMAL)
		else $error("restart did not end in normal");
	AST_OFF_IGNORE: assert property (trxMode == 2'h0
		&& $past(trxMode) == 2'h0 |=> !$rose(busWakeFlag))
		else $error("wake taken in off mode");
	AST_TXD_TIMEOUT: assert property (txdLowCnt_reg > TXD_TO_CYC + 5
		&& !$past(clrWr) && !$past(clrWr, 2) |-> trxFailFlag)
		else $error("transmit timeout not flagged");
	AST_CFG_KEPT: assert property (($rose(trxFailFlag)
		|| $rose(transceiverSupplyLowFlag)) && !$past(modeWr)
		|-> $stable(trxMode))
		else $error("fault changed configured mode");
endmodule

// file: verilog/ctw_defs.svh
// Purpose: Shared offsets, codes, field positions and timing figures.
// Assumes: 25 MHz system clock.
// Notes:   Times are in ns; cycle counts come from ctw_pkg::cycUp.
`ifndef CTW_DEFS_SVH
`define CTW_DEFS_SVH

`define CTW_CLK_MHZ        25
`define CTW_CNT_W          20
// Transceiver mode codes
`define CTW_TRX_OFF        2'h0
`define CTW_TRX_WAKE       2'h1
`define CTW_TRX_RXONLY     2'h2
`define CTW_TRX_NORMAL     2'h3
`define CTW_TRX_RESET      2'h0
// Times in ns
`define CTW_WAKE_FILTER_NS 1000
`define CTW_TXD_TO_NS      1000000
`define CTW_BUS_TO_NS      1000000
`define CTW_ENABLE_NS      10000
`define CTW_RESTART_NS     4000
// Controller register byte offsets
`define CTW_REG_MODE       8'h00
`define CTW_REG_CHIP       8'h04
`define CTW_REG_CFG        8'h08
`define CTW_REG_STAT       8'h0C
`define CTW_REG_CLR        8'h10
// Field positions
`define CTW_CFG_BWWD       0
`define CTW_CFG_WDON       1
`define CTW_CLR_FLAGS      0
`define CTW_CLR_REFUSED    1
`define CTW_STAT_WAKE      5
`define CTW_STAT_FAIL      6
`define CTW_STAT_UV        7
`define CTW_STAT_RXD       8
`define CTW_STAT_INTN      9
`define CTW_STAT_REFUSED   10
`define CTW_STAT_WDON      11

`endif

// file: verilog/ctw_device.sv
// Purpose: Transceiver mode, wake and fault control of the chip.
// Assumes: Bus level and supply monitor arrive from outside the clock.
// Notes:   Configured mode never changes on faults; only the driver does.
//
// Our own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ns
`include "ctw_defs.svh"
// Summary of operation
// - Mode stays wake capable, receive held low
// - Re-arm after leaving wake mode
// - Stop or fail-safe entry re-arms wake
// - Host picks wake or off before sleep
// - Re-arm ignores bus wake flag
// - Stop/normal wake: interrupt, flag, receive low
// - Only the host or a fail-safe request leaves stop mode
// - Stop wake enables watchdog if configured
// - Sleep wake goes restart then normal
// - Sleep wake raises no interrupt
// - Fail-safe/restart wake lands in restart
// - Host reads wake source after low receive
// - Transmit dominant timeout drops the driver
// - Driver returns once transmit goes recessive
// - Bus dominant timeout sets fail flag
// - Supply low flagged, driver off, when monitored
// - Supply recovery restores driver automatically
// - Host powers supply before normal mode
// - Receive low until mode changes
// - Off mode ignores bus wake
// - Only dominant after enabling time is sent
module ctw_device #(
	parameter int unsigned TXD_TO_CYC = ctw_pkg::cycUp(`CTW_TXD_TO_NS),
	parameter int unsigned BUS_TO_CYC = ctw_pkg::cycUp(`CTW_BUS_TO_NS)
) (
	input  wire logic     sys_clk,
	input  wire logic     arst_n,
	ctw_link_if.device    link,
	input  wire logic     busDominantPin,
	input  wire logic     supplyLowPin,
	input  wire logic     failSafeReq,
	output logic          busDriveDominant
);
	localparam int unsigned WAKE_CYC = ctw_pkg::cycUp(`CTW_WAKE_FILTER_NS);
	localparam int unsigned EN_CYC = ctw_pkg::cycUp(`CTW_ENABLE_NS);
	localparam int unsigned RST_CYC = ctw_pkg::cycUp(`CTW_RESTART_NS);

	logic [2:0]          busSync_reg;
	logic [2:0]          busSync_next;
	logic [2:0]          supSync_reg;
	logic [2:0]          supSync_next;
	logic                busDom_reg;
	logic                busDom_next;
	logic                supLow_reg;
	logic                supLow_next;
	ctw_pkg::ctw_trx_t   trx_reg;
	ctw_pkg::ctw_trx_t   trx_next;
	ctw_pkg::ctw_chip_t  chip_reg;
	ctw_pkg::ctw_chip_t  chip_next;
	logic                armed_reg;
	logic                armed_next;
	logic                woken_reg;
	logic                woken_next;
	logic                intPend_reg;
	logic                intPend_next;
	logic                wakeFlag_reg;
	logic                wakeFlag_next;
	logic                failFlag_reg;
	logic                failFlag_next;
	logic                uvFlag_reg;
	logic                uvFlag_next;
	logic                txFault_reg;
	logic                txFault_next;
	logic                needRec_reg;
	logic                needRec_next;
	logic                wdOn_reg;
	logic                wdOn_next;
	logic                rxd_reg;
	logic                rxd_next;
	logic                drive_reg;
	logic                drive_next;
	logic                wakeExpD_reg;
	logic                wakeExpD_next;

	logic wakeExp;
	logic txExp;
	logic busExp;
	logic enExp;
	logic rstExp;
	logic txdDom;
	logic active;
	logic chipRun;
	logic wakeEv;
	logic uvNow;
	logic modeChange;

	// Dominant-low transmit input from the host is on our own clock
	assign txdDom = ~link.busTransmitIn;
	assign active = (trx_reg == `CTW_TRX_NORMAL) ||
	                (trx_reg == `CTW_TRX_RXONLY);
	assign chipRun = (chip_reg == ctw_pkg::CHIP_NORMAL) ||
	                 (chip_reg == ctw_pkg::CHIP_STOP);
	assign modeChange = link.modeWr && (link.modeData != trx_reg);
	// Only an armed wake capable transceiver listens; off mode never does
	assign wakeEv = wakeExp && !wakeExpD_reg &&
	                (trx_reg == `CTW_TRX_WAKE) && armed_reg;
	assign uvNow = supLow_reg && active && chipRun;

	ctw_timer #(.LIMIT(WAKE_CYC)) wakeTimer (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.run     (busDom_reg && (trx_reg == `CTW_TRX_WAKE) && armed_reg),
		.expired (wakeExp)
	);

	ctw_timer #(.LIMIT(TXD_TO_CYC)) txdTimer (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.run     (txdDom && (trx_reg == `CTW_TRX_NORMAL)),
		.expired (txExp)
	);

	ctw_timer #(.LIMIT(BUS_TO_CYC)) busTimer (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.run     (busDom_reg && active),
		.expired (busExp)
	);

	ctw_timer #(.LIMIT(EN_CYC)) enTimer (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.run     (trx_reg == `CTW_TRX_NORMAL),
		.expired (enExp)
	);

	ctw_timer #(.LIMIT(RST_CYC)) rstTimer (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.run     (chip_reg == ctw_pkg::CHIP_RESTART),
		.expired (rstExp)
	);

	always_comb begin
		// Pin inputs: a change counts once stages two and three agree
		busSync_next = {busSync_reg[1:0], busDominantPin};
		supSync_next = {supSync_reg[1:0], supplyLowPin};
		busDom_next = (busSync_reg[2] == busSync_reg[1]) ?
		              busSync_reg[2] : busDom_reg;
		supLow_next = (supSync_reg[2] == supSync_reg[1]) ?
		              supSync_reg[2] : supLow_reg;
		wakeExpD_next = wakeExp;

		// Faults never touch trx_reg, so the configured mode survives
		trx_next = link.modeWr ? link.modeData : trx_reg;

		chip_next = chip_reg;
		if (failSafeReq) begin
			chip_next = ctw_pkg::CHIP_FAILSAFE;
		end else if (wakeEv && !chipRun) begin
			chip_next = ctw_pkg::CHIP_RESTART;
		end else if (link.chipWr) begin
			chip_next = link.chipData;
		end else if (chip_reg == ctw_pkg::CHIP_RESTART && rstExp) begin
			chip_next = ctw_pkg::CHIP_NORMAL;
		end

		// Independent of the wake flag: the mode toggle alone re-arms
		armed_next = armed_reg;
		if (wakeEv) begin
			armed_next = 1'b0;
		end
		if (trx_reg != `CTW_TRX_WAKE) begin
			armed_next = 1'b1;
		end
		if (chip_next != chip_reg && (chip_next == ctw_pkg::CHIP_STOP ||
		    chip_next == ctw_pkg::CHIP_FAILSAFE)) begin
			armed_next = 1'b1;
		end

		// Receive held low from the wake until the mode changes
		woken_next = wakeEv ? 1'b1 :
		             (modeChange ? 1'b0 : woken_reg);

		// Interrupt only while the chip runs; sleep exit stays quiet
		intPend_next = (wakeEv && chipRun) ? 1'b1 :
		               (link.clrWr ? 1'b0 : intPend_reg);
		wakeFlag_next = wakeEv ? 1'b1 :
		                (link.clrWr ? 1'b0 : wakeFlag_reg);
		failFlag_next = (txExp || busExp) ? 1'b1 :
		                (link.clrWr ? 1'b0 : failFlag_reg);
		uvFlag_next = uvNow ? 1'b1 :
		              (link.clrWr ? 1'b0 : uvFlag_reg);

		wdOn_next = link.wdWr ? link.wdData : wdOn_reg;
		if (wakeEv && chip_reg == ctw_pkg::CHIP_STOP &&
		    link.watchdogOnBusWakeEnable) begin
			wdOn_next = 1'b1;
		end

		// Time-out holds until transmit returns recessive
		txFault_next = txExp ? 1'b1 :
		               (!txdDom ? 1'b0 : txFault_reg);

		// After enabling, wait for a recessive bit before driving
		needRec_next = needRec_reg;
		if (trx_next == `CTW_TRX_NORMAL && trx_reg != `CTW_TRX_NORMAL) begin
			needRec_next = 1'b1;
		end else if (enExp && !txdDom) begin
			needRec_next = 1'b0;
		end

		// Supply recovery clears uvNow and the driver comes back
		drive_next = (trx_reg == `CTW_TRX_NORMAL) && chipRun && enExp &&
		             !needRec_reg && !txFault_reg && !txExp &&
		             !uvNow && txdDom;

		if (woken_next) begin
			rxd_next = 1'b0;
		end else if (active) begin
			rxd_next = ~busDom_reg;
		end else begin
			rxd_next = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			busSync_reg <= 3'h0;
			supSync_reg <= 3'h0;
			busDom_reg <= 1'b0;
			supLow_reg <= 1'b0;
			trx_reg <= `CTW_TRX_RESET;
			chip_reg <= ctw_pkg::CHIP_NORMAL;
			armed_reg <= 1'b1;
			woken_reg <= 1'b0;
			intPend_reg <= 1'b0;
			wakeFlag_reg <= 1'b0;
			failFlag_reg <= 1'b0;
			uvFlag_reg <= 1'b0;
			txFault_reg <= 1'b0;
			needRec_reg <= 1'b0;
			wdOn_reg <= 1'b0;
			rxd_reg <= 1'b1;
			drive_reg <= 1'b0;
			wakeExpD_reg <= 1'b0;
		end else begin
			busSync_reg <= busSync_next;
			supSync_reg <= supSync_next;
			busDom_reg <= busDom_next;
			supLow_reg <= supLow_next;
			trx_reg <= trx_next;
			chip_reg <= chip_next;
			armed_reg <= armed_next;
			woken_reg <= woken_next;
			intPend_reg <= intPend_next;
			wakeFlag_reg <= wakeFlag_next;
			failFlag_reg <= failFlag_next;
			uvFlag_reg <= uvFlag_next;
			txFault_reg <= txFault_next;
			needRec_reg <= needRec_next;
			wdOn_reg <= wdOn_next;
			rxd_reg <= rxd_next;
			drive_reg <= drive_next;
			wakeExpD_reg <= wakeExpD_next;
		end
	end

	assign link.busReceiveOut = rxd_reg;
	assign link.intN = ~intPend_reg;
	assign link.trxMode = trx_reg;
	assign link.chipMode = chip_reg;
	assign link.busWakeFlag = wakeFlag_reg;
	assign link.trxFailFlag = failFlag_reg;
	assign link.transceiverSupplyLowFlag = uvFlag_reg;
	assign link.watchdogOn = wdOn_reg;
	assign busDriveDominant = drive_reg;
endmodule

// file: verilog/ctw_host.sv
// Purpose: Host end: AHB-Lite registers steering the transceiver link.
// Assumes: Single-word transfers, zero wait states, OKAY only.
// Notes:   Mode writes reach the link two cycles after the data phase.
`timescale 1ns/1ns
`include "ctw_defs.svh"
module ctw_host (
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	ctw_link_if.host         link,
	input  wire logic        ctrlTxd,
	output logic             ctrlRxd,
	output logic             supplyOn
);
	localparam int unsigned EN_CYC = ctw_pkg::cycUp(`CTW_ENABLE_NS);
	localparam logic [15:0] EN_CNT = 16'(EN_CYC);

	logic                wPend_reg, wPend_next;
	logic [7:0]          wAddr_reg, wAddr_next;
	logic [31:0]         rdata_reg, rdata_next;
	logic                pend_reg, pend_next;
	ctw_pkg::ctw_trx_t   mode_reg, mode_next;
	logic                modeWr_reg, modeWr_next;
	logic                chipWr_reg, chipWr_next;
	ctw_pkg::ctw_chip_t  chip_reg, chip_next;
	logic                bwwd_reg, bwwd_next;
	logic                wdWr_reg, wdWr_next;
	logic                wdData_reg, wdData_next;
	logic                clrWr_reg, clrWr_next;
	logic                refused_reg, refused_next;
	logic                supOn_reg, supOn_next;
	logic                txd_reg, txd_next;
	logic                rxd_reg, rxd_next;
	logic [15:0]         hold_reg, hold_next;

	logic addrPhase;
	logic dataWr;
	logic [31:0] stat;

	assign addrPhase = hsel && hready && htrans[1];
	assign dataWr = wPend_reg;
	assign stat = {20'h0, link.watchdogOn, refused_reg, link.intN,
	               link.busReceiveOut, link.transceiverSupplyLowFlag,
	               link.trxFailFlag, link.busWakeFlag,
	               3'(link.chipMode), link.trxMode};

	always_comb begin
		wPend_next = addrPhase && hwrite;
		wAddr_next = addrPhase ? haddr[7:0] : wAddr_reg;
		rdata_next = 32'h0;
		if (addrPhase && !hwrite) begin
			if (haddr[7:0] == `CTW_REG_MODE) begin
				rdata_next = {30'h0, mode_reg};
			end else if (haddr[7:0] == `CTW_REG_CHIP) begin
				rdata_next = {29'h0, 3'(chip_reg)};
			end else if (haddr[7:0] == `CTW_REG_CFG) begin
				rdata_next = {30'h0, link.watchdogOn, bwwd_reg};
			end else if (haddr[7:0] == `CTW_REG_STAT) begin
				rdata_next = stat;
			end
		end
		pend_next = 1'b0;
		mode_next = mode_reg;
		modeWr_next = pend_reg;
		chipWr_next = 1'b0;
		chip_next = chip_reg;
		bwwd_next = bwwd_reg;
		wdWr_next = 1'b0;
		wdData_next = wdData_reg;
		clrWr_next = 1'b0;
		refused_next = refused_reg;
		supOn_next = supOn_reg;
		hold_next = (hold_reg != 16'h0) ? hold_reg - 16'h1 : hold_reg;
		if (dataWr) begin
			if (wAddr_reg == `CTW_REG_MODE) begin
				// Supply switches first; the mode follows a cycle later
				pend_next = 1'b1;
				mode_next = hwdata[1:0];
				supOn_next = hwdata[1];
			end else if (wAddr_reg == `CTW_REG_CHIP) begin
				if (ctw_pkg::ctw_chip_t'(hwdata[2:0]) ==
				    ctw_pkg::CHIP_SLEEP && link.trxMode[1]) begin
					refused_next = 1'b1;
				end else begin
					chipWr_next = 1'b1;
					chip_next = ctw_pkg::ctw_chip_t'(hwdata[2:0]);
				end
			end else if (wAddr_reg == `CTW_REG_CFG) begin
				bwwd_next = hwdata[`CTW_CFG_BWWD];
				wdWr_next = 1'b1;
				wdData_next = hwdata[`CTW_CFG_WDON];
			end else if (wAddr_reg == `CTW_REG_CLR) begin
				clrWr_next = hwdata[`CTW_CLR_FLAGS];
				if (hwdata[`CTW_CLR_REFUSED]) begin
					refused_next = 1'b0;
				end
			end
		end
		if (pend_reg && mode_reg == `CTW_TRX_NORMAL) begin
			hold_next = EN_CNT;
		end
		// Transmit kept recessive through the enabling time
		txd_next = (hold_next != 16'h0) ? 1'b1 : ctrlTxd;
		rxd_next = link.busReceiveOut;
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wPend_reg <= 1'b0;
			wAddr_reg <= 8'h0;
			rdata_reg <= 32'h0;
			pend_reg <= 1'b0;
			mode_reg <= `CTW_TRX_RESET;
			modeWr_reg <= 1'b0;
			chipWr_reg <= 1'b0;
			chip_reg <= ctw_pkg::CHIP_NORMAL;
			bwwd_reg <= 1'b0;
			wdWr_reg <= 1'b0;
			wdData_reg <= 1'b0;
			clrWr_reg <= 1'b0;
			refused_reg <= 1'b0;
			supOn_reg <= 1'b0;
			txd_reg <= 1'b1;
			rxd_reg <= 1'b1;
			hold_reg <= 16'h0;
		end else begin
			wPend_reg <= wPend_next;
			wAddr_reg <= wAddr_next;
			rdata_reg <= rdata_next;
			pend_reg <= pend_next;
			mode_reg <= mode_next;
			modeWr_reg <= modeWr_next;
			chipWr_reg <= chipWr_next;
			chip_reg <= chip_next;
			bwwd_reg <= bwwd_next;
			wdWr_reg <= wdWr_next;
			wdData_reg <= wdData_next;
			clrWr_reg <= clrWr_next;
			refused_reg <= refused_next;
			supOn_reg <= supOn_next;
			txd_reg <= txd_next;
			rxd_reg <= rxd_next;
			hold_reg <= hold_next;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_reg;
	assign link.busTransmitIn = txd_reg;
	assign link.modeWr = modeWr_reg;
	assign link.modeData = mode_reg;
	assign link.chipWr = chipWr_reg;
	assign link.chipData = chip_reg;
	assign link.watchdogOnBusWakeEnable = bwwd_reg;
	assign link.wdWr = wdWr_reg;
	assign link.wdData = wdData_reg;
	assign link.clrWr = clrWr_reg;
	assign ctrlRxd = rxd_reg;
	assign supplyOn = supOn_reg;
endmodule

// file: verilog/ctw_link_if.sv
// Purpose: Link between the transceiver controller and its host end.
// Assumes: Both ends run on sys_clk.
// Notes:   Strobes are one-cycle pulses; everything else is a level.
`timescale 1ns/1ns
interface ctw_link_if;
	logic                busTransmitIn;
	logic                busReceiveOut;
	logic                intN;
	logic                modeWr;
	ctw_pkg::ctw_trx_t   modeData;
	logic                chipWr;
	ctw_pkg::ctw_chip_t  chipData;
	logic                watchdogOnBusWakeEnable;
	logic                wdWr;
	logic                wdData;
	logic                clrWr;
	ctw_pkg::ctw_trx_t   trxMode;
	ctw_pkg::ctw_chip_t  chipMode;
	logic                busWakeFlag;
	logic                trxFailFlag;
	logic                transceiverSupplyLowFlag;
	logic                watchdogOn;

	modport device (
		input  busTransmitIn,
		output busReceiveOut,
		output intN,
		input  modeWr,
		input  modeData,
		input  chipWr,
		input  chipData,
		input  watchdogOnBusWakeEnable,
		input  wdWr,
		input  wdData,
		input  clrWr,
		output trxMode,
		output chipMode,
		output busWakeFlag,
		output trxFailFlag,
		output transceiverSupplyLowFlag,
		output watchdogOn
	);

	modport host (
		output busTransmitIn,
		input  busReceiveOut,
		input  intN,
		output modeWr,
		output modeData,
		output chipWr,
		output chipData,
		output watchdogOnBusWakeEnable,
		output wdWr,
		output wdData,
		output clrWr,
		input  trxMode,
		input  chipMode,
		input  busWakeFlag,
		input  trxFailFlag,
		input  transceiverSupplyLowFlag,
		input  watchdogOn
	);
endinterface

// file: verilog/ctw_pkg.sv
// Purpose: Types and shared arithmetic for the transceiver control pair.
// Assumes: ctw_defs.svh supplies the clock rate.
// Notes:   Nothing here is imported; users write ctw_pkg::name.
`include "ctw_defs.svh"
package ctw_pkg;
	typedef enum logic [2:0] {
		CHIP_NORMAL,
		CHIP_STOP,
		CHIP_SLEEP,
		CHIP_RESTART,
		CHIP_FAILSAFE
	} ctw_chip_t;

	typedef logic [1:0] ctw_trx_t;

	// Least times round up; never below one cycle
	function automatic int unsigned cycUp(input int unsigned ns);
		int unsigned c;
		c = (ns * `CTW_CLK_MHZ + 999) / 1000;
		return (c == 0) ? 1 : c;
	endfunction
endpackage

// file: verilog/ctw_timer.sv
// Purpose: Duration counter; flags a condition held longer than LIMIT.
// Assumes: run is synchronous to sys_clk.
// Notes:   Restarts from zero whenever run drops.
`timescale 1ns/1ns
`include "ctw_defs.svh"
module ctw_timer #(
	parameter int unsigned LIMIT = 1
) (
	input  wire logic sys_clk,
	input  wire logic arst_n,
	input  wire logic run,
	output logic      expired
);
	localparam logic [`CTW_CNT_W-1:0] LIM = `CTW_CNT_W'(LIMIT);

	logic [`CTW_CNT_W-1:0] cnt_reg;
	logic [`CTW_CNT_W-1:0] cnt_next;
	logic                  exp_reg;
	logic                  exp_next;

	always_comb begin
		cnt_next = '0;
		exp_next = 1'b0;
		if (run) begin
			// Saturate so a long condition keeps the flag up
			cnt_next = (cnt_reg == LIM) ? cnt_reg : cnt_reg + 1'b1;
			exp_next = (cnt_reg == LIM);
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= '0;
			exp_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			exp_reg <= exp_next;
		end
	end

	assign expired = exp_reg;
endmodule
